// ===== cpt_regs.svh
`ifndef CPT_REGS_SVH
`define CPT_REGS_SVH
// What this block does
// - Two 8-bit counters form one 16-bit up-counter
// - PWM width match toggles flop, counting continues
// - PWM overflow toggles flop, clears, raises interrupt
// - Flop loads from init bit; reset clears it
// - Both output pins show inverted flop state
// - Running PWM buffers width, transfers at interrupt
// - Stopped PWM width write takes effect immediately
// - PWM width read returns previous value until interrupt
// - Stop holds pin; init bit changes afterwards
// - Pulse mode: width toggles, period toggles clears interrupts
// - Pulse mode compares unbuffered; unchanged while running
// - Upper control bit 3 runs the timer
// - Upper control bit 7 is output init level
// - Warm-up mode compares only upper period byte
// - Warm-up match clears counter and raises interrupt

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CPT_LTC_OFS 8'h00
`define CPT_UTC_OFS 8'h04
`define CPT_WLO_OFS 8'h08
`define CPT_WHI_OFS 8'h0C
`define CPT_PLO_OFS 8'h10
`define CPT_PHI_OFS 8'h14
`define CPT_CLO_OFS 8'h18
`define CPT_CHI_OFS 8'h1C
`define CPT_STA_OFS 8'h20

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CPT_RUN_BIT 3
`define CPT_OLI_BIT 7
`define CPT_STA_FF_BIT 0
`define CPT_STA_RUN_BIT 1
`define CPT_CTL_RST 8'h00
`define CPT_BYTE_RST 8'h00
`define CPT_CMP_RST 16'h0000
`define CPT_CNT_MAX 16'hFFFF

// ----------------------------------------
// Prescaler masks
// ----------------------------------------
`define CPT_DIV_2048 11'h7FF
`define CPT_DIV_128 11'h07F
`define CPT_DIV_32 11'h01F
`define CPT_DIV_8 11'h007
`define CPT_DIV_2 11'h001
`endif

// ===== cpt_pkg.sv
package cpt_pkg;
   typedef enum logic [1:0] {
      cpt_mode_timer = 2'b00,
      cpt_mode_pwm = 2'b01,
      cpt_mode_ppg = 2'b10,
      cpt_mode_warm = 2'b11
   } cpt_mode_t;

   typedef enum logic [2:0] {
      cpt_clk_div2048 = 3'b000,
      cpt_clk_div128 = 3'b001,
      cpt_clk_div32 = 3'b010,
      cpt_clk_div8 = 3'b011,
      cpt_clk_div2 = 3'b100,
      cpt_clk_div1 = 3'b101,
      cpt_clk_ext = 3'b111
   } cpt_clk_sel_t;
endpackage : cpt_pkg

// ===== cpt_if.sv
`timescale 1ns/1ps
interface cpt_if;
   cpt_pkg::cpt_clk_sel_t clk_sel;
   logic tick;
   logic acc_stb;
   logic acc_we;
   logic acc_sel0;
   logic [7:0] acc_adr;
   logic [7:0] acc_wdata;
   logic [7:0] rdata;

   modport tick_mp (input clk_sel, output tick);
   modport bus_mp (output acc_stb, output acc_we, output acc_sel0, output acc_adr,
      output acc_wdata, input rdata);
   modport core_mp (input tick, input acc_stb, input acc_we, input acc_sel0,
      input acc_adr, input acc_wdata, output clk_sel, output rdata);
endinterface : cpt_if

// ===== cpt_tick.sv
`timescale 1ns/1ps
`include "cpt_regs.svh"
module cpt_tick (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ext_i,
   cpt_if.tick_mp tk
);
   import cpt_pkg::*;

   logic [10:0] div_reg;
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   logic tick_reg;
   logic tick_next;

   // ----------------------------------------
   // Free-running prescaler
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         div_reg <= 11'h000;
      else
         div_reg <= div_reg + 11'h001;
   end

   // ----------------------------------------
   // External input, two flops before use
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg <= 1'b1;
      end
      else
      begin
         sync1_reg <= ext_i;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   always_comb
   begin
      unique case (tk.clk_sel)
         cpt_clk_div2048: tick_next = (div_reg & `CPT_DIV_2048) == `CPT_DIV_2048;
         cpt_clk_div128: tick_next = (div_reg & `CPT_DIV_128) == `CPT_DIV_128;
         cpt_clk_div32: tick_next = (div_reg & `CPT_DIV_32) == `CPT_DIV_32;
         cpt_clk_div8: tick_next = (div_reg & `CPT_DIV_8) == `CPT_DIV_8;
         cpt_clk_div2: tick_next = (div_reg & `CPT_DIV_2) == `CPT_DIV_2;
         cpt_clk_div1: tick_next = 1'b1;
         cpt_clk_ext: tick_next = prev_reg & ~sync2_reg;
         // Reserved select code stalls the count
         default: tick_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tick_reg <= 1'b0;
      else
         tick_reg <= tick_next;
   end

   assign tk.tick = tick_reg;
endmodule : cpt_tick

// ===== cpt_wbs.sv
`timescale 1ns/1ps
module cpt_wbs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   cpt_if.bus_mp bus
);
   import cpt_pkg::*;

   logic req;
   logic ack_reg;
   logic [31:0] dat_reg;

   // Read data is latched as the request is seen; a write lands only at
   // the edge where the master samples ack, so a held request acts once
   assign req = wb_cyc_i & wb_stb_i;
   assign bus.acc_stb = req & ack_reg;
   assign bus.acc_we = wb_we_i;
   assign bus.acc_sel0 = wb_sel_i[0];
   assign bus.acc_adr = wb_adr_i;
   assign bus.acc_wdata = wb_dat_i[7:0];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_reg <= 1'b0;
      else
         ack_reg <= req & ~ack_reg;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_reg <= 32'h0000_0000;
      else if (req && !ack_reg && !wb_we_i)
         dat_reg <= {24'h00_0000, bus.rdata};
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
endmodule : cpt_wbs

// ===== cpt_timer.sv
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "cpt_regs.svh"
module cpt_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic external_count_input_i,
   output logic pwm_output_pin_n_o,
   output logic pulse_gen_output_pin_n_o,
   output logic period_interrupt_o
);
   import cpt_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   cpt_if cif ();

   logic [7:0] lower_timer_control_reg;
   logic [7:0] upper_timer_control_reg;
   logic [7:0] width_buf_lo_reg;
   logic [7:0] width_buf_hi_reg;
   logic [15:0] width_act_reg;
   logic [15:0] period_reg;
   logic [15:0] cnt_reg;
   logic output_toggle_flop_reg;
   logic out_n_reg;
   logic irq_reg;

   logic wr;
   logic wr_ltc;
   logic wr_utc;
   logic wr_wlo;
   logic wr_whi;
   logic wr_plo;
   logic wr_phi;
   logic run;
   logic start;
   logic load_init;
   logic step;
   logic tog;
   logic clr;
   logic pwm_run;
   cpt_mode_t mode;
   logic [7:0] rdata_next;

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   cpt_wbs u_wbs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .bus(cif.bus_mp)
   );

   cpt_tick u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ext_i(external_count_input_i),
      .tk(cif.tick_mp)
   );

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign wr = cif.acc_stb & cif.acc_we & cif.acc_sel0;
   assign wr_ltc = wr && (cif.acc_adr == `CPT_LTC_OFS);
   assign wr_utc = wr && (cif.acc_adr == `CPT_UTC_OFS);
   assign wr_wlo = wr && (cif.acc_adr == `CPT_WLO_OFS);
   assign wr_whi = wr && (cif.acc_adr == `CPT_WHI_OFS);
   assign wr_plo = wr && (cif.acc_adr == `CPT_PLO_OFS);
   assign wr_phi = wr && (cif.acc_adr == `CPT_PHI_OFS);

   assign run = upper_timer_control_reg[`CPT_RUN_BIT];
   assign mode = cpt_mode_t'(upper_timer_control_reg[1:0]);
   assign cif.clk_sel = cpt_clk_sel_t'(lower_timer_control_reg[2:0]);
   assign step = run & cif.tick;
   assign pwm_run = run && (mode == cpt_mode_pwm);
   // Init level only loads on a write made while stopped, so the
   // write that stops the timer leaves the pin where it was
   assign load_init = wr_utc & ~run;
   assign start = load_init & cif.acc_wdata[`CPT_RUN_BIT];

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         lower_timer_control_reg <= `CPT_CTL_RST;
      else if (wr_ltc)
         lower_timer_control_reg <= cif.acc_wdata;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         upper_timer_control_reg <= `CPT_CTL_RST;
      else if (wr_utc)
         upper_timer_control_reg <= cif.acc_wdata;
   end

   // ----------------------------------------
   // Match logic per mode
   // ----------------------------------------
   always_comb
   begin
      tog = 1'b0;
      clr = 1'b0;
      unique case (mode)
         cpt_mode_timer:
         begin
            clr = cnt_reg == period_reg;
         end
         cpt_mode_pwm:
         begin
            tog = (cnt_reg == width_act_reg) ^ (cnt_reg == `CPT_CNT_MAX);
            clr = cnt_reg == `CPT_CNT_MAX;
         end
         cpt_mode_ppg:
         begin
            tog = (cnt_reg == width_act_reg) ^ (cnt_reg == period_reg);
            clr = cnt_reg == period_reg;
         end
         cpt_mode_warm:
         begin
            clr = cnt_reg[15:8] == period_reg[15:8];
         end
      endcase
   end

   // ----------------------------------------
   // Counter and interrupt
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt_reg <= `CPT_CMP_RST;
      else if (start)
         cnt_reg <= `CPT_CMP_RST;
      else if (step)
         cnt_reg <= clr ? `CPT_CMP_RST : cnt_reg + 16'h0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_reg <= 1'b0;
      else
         irq_reg <= step & clr;
   end

   // ----------------------------------------
   // Toggle flop and pins
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         output_toggle_flop_reg <= 1'b0;
      else if (load_init)
         output_toggle_flop_reg <= cif.acc_wdata[`CPT_OLI_BIT];
      else if (step && tog)
         output_toggle_flop_reg <= ~output_toggle_flop_reg;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         out_n_reg <= 1'b1;
      else if (load_init)
         out_n_reg <= ~cif.acc_wdata[`CPT_OLI_BIT];
      else if (step && tog)
         out_n_reg <= output_toggle_flop_reg;
   end

   assign pwm_output_pin_n_o = out_n_reg;
   assign pulse_gen_output_pin_n_o = out_n_reg;
   assign period_interrupt_o = irq_reg;

   // ----------------------------------------
   // Compare registers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         width_buf_lo_reg <= `CPT_BYTE_RST;
         width_buf_hi_reg <= `CPT_BYTE_RST;
      end
      else
      begin
         if (wr_wlo)
            width_buf_lo_reg <= cif.acc_wdata;
         if (wr_whi)
            width_buf_hi_reg <= cif.acc_wdata;
      end
   end

   // A write landing with the transfer keeps the old buffer for one period
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         width_act_reg <= `CPT_CMP_RST;
      else if (pwm_run)
      begin
         if (step && clr)
            width_act_reg <= {width_buf_hi_reg, width_buf_lo_reg};
      end
      else
      begin
         if (wr_wlo)
            width_act_reg[7:0] <= cif.acc_wdata;
         if (wr_whi)
            width_act_reg[15:8] <= cif.acc_wdata;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         period_reg <= `CPT_CMP_RST;
      else
      begin
         if (wr_plo)
            period_reg[7:0] <= cif.acc_wdata;
         if (wr_phi)
            period_reg[15:8] <= cif.acc_wdata;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_comb
   begin
      unique case (cif.acc_adr)
         `CPT_LTC_OFS: rdata_next = lower_timer_control_reg;
         `CPT_UTC_OFS: rdata_next = upper_timer_control_reg;
         `CPT_WLO_OFS: rdata_next = width_act_reg[7:0];
         `CPT_WHI_OFS: rdata_next = width_act_reg[15:8];
         `CPT_PLO_OFS: rdata_next = period_reg[7:0];
         `CPT_PHI_OFS: rdata_next = period_reg[15:8];
         `CPT_CLO_OFS: rdata_next = cnt_reg[7:0];
         `CPT_CHI_OFS: rdata_next = cnt_reg[15:8];
         `CPT_STA_OFS: rdata_next = {6'h00, run, output_toggle_flop_reg};
         default: rdata_next = 8'h00;
      endcase
   end

   assign cif.rdata = rdata_next;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   count_step_a: assert property (
      step && !clr && !start |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("counter did not advance on a tick");

   pwm_width_a: assert property (
      step && mode == cpt_mode_pwm && cnt_reg == width_act_reg
      && cnt_reg != `CPT_CNT_MAX && !load_init
      |=> output_toggle_flop_reg != $past(output_toggle_flop_reg)
      && cnt_reg != `CPT_CMP_RST)
      else $error("pwm width match did not toggle");

   pwm_wrap_a: assert property (
      step && mode == cpt_mode_pwm && cnt_reg == `CPT_CNT_MAX && !start
      |=> cnt_reg == `CPT_CMP_RST && irq_reg)
      else $error("pwm overflow did not clear and interrupt");

   pin_invert_a: assert property (
      ##1 pwm_output_pin_n_o == !output_toggle_flop_reg
      && pulse_gen_output_pin_n_o == pwm_output_pin_n_o)
      else $error("output pins not inverse of flop");

   width_xfer_a: assert property (
      pwm_run && step && clr
      |=> width_act_reg == {$past(width_buf_hi_reg), $past(width_buf_lo_reg)})
      else $error("buffered width not transferred");

   width_hold_a: assert property (
      pwm_run && !(step && clr) |=> $stable(width_act_reg))
      else $error("active width changed mid period");

   stop_hold_a: assert property (
      !run && !load_init |=> $stable(output_toggle_flop_reg))
      else $error("stopped flop changed level");

   init_load_a: assert property (
      load_init && !cif.acc_wdata[`CPT_OLI_BIT] |=> !output_toggle_flop_reg
      ##0 pwm_output_pin_n_o)
      else $error("init bit clear did not force pin high");

   ppg_period_a: assert property (
      step && mode == cpt_mode_ppg && cnt_reg == period_reg && !start
      |=> cnt_reg == `CPT_CMP_RST && irq_reg ##1 !irq_reg)
      else $error("period match did not clear and pulse");

   warm_cmp_a: assert property (
      step && mode == cpt_mode_warm && !start
      && cnt_reg[15:8] == period_reg[15:8]
      |=> cnt_reg == `CPT_CMP_RST && irq_reg && $stable(output_toggle_flop_reg))
      else $error("warm-up upper byte match missed");

   stop_write_a: assert property (
      wr_utc && run && !(step && tog)
      |=> $stable(output_toggle_flop_reg))
      else $error("stopping write changed the flop");

   init_set_a: assert property (
      load_init && cif.acc_wdata[`CPT_OLI_BIT]
      |=> output_toggle_flop_reg && !pwm_output_pin_n_o)
      else $error("init bit set did not load the flop");

   stop_count_a: assert property (
      !run && !start |=> $stable(cnt_reg))
      else $error("stopped counter moved");

   idle_load_lo_a: assert property (
      !pwm_run && wr_wlo
      |=> width_act_reg[7:0] == $past(cif.acc_wdata))
      else $error("stopped width low byte not loaded");

   idle_load_hi_a: assert property (
      !pwm_run && wr_whi
      |=> width_act_reg[15:8] == $past(cif.acc_wdata))
      else $error("stopped width high byte not loaded");

   period_load_a: assert property (
      wr_phi |=> period_reg[15:8] == $past(cif.acc_wdata)
      && period_reg[7:0] == $past(period_reg[7:0]))
      else $error("period high byte not taken at once");
endmodule : cpt_timer

// ===== cpt_ext_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Circuit on the far side of the pins
// ----------------------------------------
module cpt_ext_model (
   input wire logic clk_i,
   input wire logic pin_n_i,
   output logic count_o,
   output logic [31:0] low_len_o
);
   logic [31:0] run_reg;

   initial
   begin
      count_o = 1'b1;
      run_reg = 32'h0000_0000;
      low_len_o = 32'h0000_0000;
   end

   // Length of the last finished low stretch of the pin, in clocks
   always @(posedge clk_i)
   begin
      if (pin_n_i === 1'b0)
         run_reg <= run_reg + 32'h0000_0001;
      else
      begin
         if (run_reg != 32'h0000_0000)
            low_len_o <= run_reg;
         run_reg <= 32'h0000_0000;
      end
   end

   // Each level held for half clocks; half must stay at one or more
   task automatic pulses(input int n, input int half);
      repeat (n)
      begin
         repeat (half) @(posedge clk_i);
         count_o <= 1'b0;
         repeat (half) @(posedge clk_i);
         count_o <= 1'b1;
      end
   endtask : pulses
endmodule : cpt_ext_model

// ===== tb.sv
`timescale 1ns/1ps
`include "cpt_regs.svh"
module tb;
   logic clk_i;
   logic rst_i;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic ext_count;
   logic pwm_n;
   logic ppg_n;
   logic irq;
   logic [31:0] low_len;
   logic port_latch;
   logic [31:0] rd;
   int errors;
   int comparisons;
   int cyc_cnt;
   int last_irq;
   int gap;
   logic [7:0] ofs_tab [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
      8'h20, 8'h40};
   logic [7:0] sel_tab [3] = '{8'h05, 8'h05, 8'h04};
   logic [15:0] per_tab [3] = '{16'h000A, 16'h0014, 16'h000A};
   int gap_tab [3] = '{11, 21, 22};
   int low_tab [3] = '{7, 17, 14};

   cpt_timer uut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .external_count_input_i(ext_count),
      .pwm_output_pin_n_o(pwm_n),
      .pulse_gen_output_pin_n_o(ppg_n),
      .period_interrupt_o(irq)
   );

   cpt_ext_model ext (
      .clk_i(clk_i),
      .pin_n_i(pwm_n & port_latch),
      .count_o(ext_count),
      .low_len_o(low_len)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Spacing of interrupt pulses in clocks
   always @(posedge clk_i)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (irq === 1'b1)
      begin
         gap <= cyc_cnt - last_irq;
         last_irq <= cyc_cnt;
      end
   end

   // ----------------------------------------
   // Bench tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb_cycle

   task automatic wb_write(input logic [7:0] a, input logic [7:0] d);
      wb_cycle(1'b1, a, d);
   endtask : wb_write

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb_cycle(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask : rd_chk

   // Low byte first, never one byte alone
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wb_write(a, v[7:0]);
      wb_write(a + 8'h04, v[15:8]);
   endtask : wr16

   task automatic wait_irq(input int limit);
      int k;
      k = 0;
      @(posedge clk_i);
      while (irq !== 1'b1 && k < limit)
      begin
         @(posedge clk_i);
         k++;
      end
      // Monitors update on this edge; read them once settled
      #1;
      if (k >= limit)
      begin
         errors++;
         $display("Interrupt wait expired at %0t", $time);
      end
   endtask : wait_irq

   initial
   begin
      repeat (95000) @(posedge clk_i);
      errors++;
      $display("Watchdog expired at %0t", $time);
      stop_test();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      int k;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0000_0000;
      errors = 0;
      comparisons = 0;
      cyc_cnt = 0;
      last_irq = 0;
      gap = 0;
      port_latch = 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({31'h0, pwm_n}, 32'h1);
      foreach (ofs_tab[i])
         rd_chk(ofs_tab[i], 32'h0000_0000);
      // Event counting on the external input, across the byte carry
      wb_write(`CPT_LTC_OFS, 8'h07);
      wr16(`CPT_PLO_OFS, 16'hFFFF);
      wb_write(`CPT_UTC_OFS, 8'h08);
      ext.pulses(260, 4);
      repeat (8) @(posedge clk_i);
      rd_chk(`CPT_CLO_OFS, 32'h0000_0004);
      rd_chk(`CPT_CHI_OFS, 32'h0000_0001);
      wb_write(`CPT_UTC_OFS, 8'h00);
      // Pulse mode, compares written only while stopped
      for (int i = 0; i < 3; i++)
      begin
         wb_write(`CPT_LTC_OFS, sel_tab[i]);
         wb_write(`CPT_UTC_OFS, 8'h02);
         wr16(`CPT_WLO_OFS, 16'h0003);
         wr16(`CPT_PLO_OFS, per_tab[i]);
         wb_write(`CPT_UTC_OFS, 8'h0A);
         wait_irq(100);
         wait_irq(100);
         chk(32'(gap), 32'(gap_tab[i]));
         chk(low_len, 32'(low_tab[i]));
         chk({31'h0, ppg_n}, {31'h0, pwm_n});
         wb_write(`CPT_UTC_OFS, 8'h02);
      end
      // Warm-up: low period byte ignored, init bit kept at 0
      wb_write(`CPT_LTC_OFS, 8'h05);
      wb_write(`CPT_UTC_OFS, 8'h03);
      wr16(`CPT_PLO_OFS, 16'h01FF);
      wb_write(`CPT_UTC_OFS, 8'h0B);
      wait_irq(600);
      wait_irq(600);
      chk(32'(gap), 32'd257);
      chk({31'h0, pwm_n}, 32'h1);
      wb_write(`CPT_UTC_OFS, 8'h03);
      // PWM: immediate load while stopped, buffered while running
      wb_write(`CPT_UTC_OFS, 8'h01);
      wr16(`CPT_WLO_OFS, 16'h1000);
      rd_chk(`CPT_WHI_OFS, 32'h0000_0010);
      wb_write(`CPT_UTC_OFS, 8'h09);
      wr16(`CPT_WLO_OFS, 16'h2034);
      rd_chk(`CPT_WHI_OFS, 32'h0000_0010);
      wait_irq(70000);
      repeat (2) @(posedge clk_i);
      chk(low_len, 32'h0000_EFFF);
      rd_chk(`CPT_WLO_OFS, 32'h0000_0034);
      rd_chk(`CPT_WHI_OFS, 32'h0000_0020);
      // Stop while the pin is low; the stopping write keeps the level
      k = 0;
      while (pwm_n !== 1'b0 && k < 12000)
      begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 12000)
      begin
         errors++;
         $display("Pin wait expired at %0t", $time);
      end
      wb_write(`CPT_UTC_OFS, 8'h01);
      wb_cycle(1'b0, `CPT_CLO_OFS, 8'h00);
      k = int'(rd);
      repeat (5) @(posedge clk_i);
      rd_chk(`CPT_CLO_OFS, 32'(k));
      chk({31'h0, pwm_n}, 32'h0);
      wb_write(`CPT_UTC_OFS, 8'h01);
      repeat (3) @(posedge clk_i);
      chk({31'h0, pwm_n}, 32'h1);
      wb_write(`CPT_UTC_OFS, 8'h81);
      repeat (3) @(posedge clk_i);
      chk({31'h0, pwm_n}, 32'h0);
      chk({31'h0, ppg_n}, 32'h0);
      stop_test();
   end
endmodule : tb
